// ===== hw/video_input_select_stb_diag.sv
`timescale 1ns/100ps

// Operation
// R1 - Five-bit format code, reserved codes route nothing
// R2 - Format code also sets decoder core format
// R3 - Composite codes 0-7 per variant mapping
// R4 - Four-input composite: codes 0,1,6,7 only
// R5 - Codes 8-11 select luma/chroma pairs
// R6 - Codes 12,13 select component triples
// R7 - Codes 14-17 select differential pairs
// R8 - Composite routing powers down unused inputs
// R9 - Host uses manual routing for four-input component
// R10 - Sense above slice level is an event
// R11 - Event raises interrupt request pin
// R12 - Status shows which sense pin tripped
// R13 - Diagnostics disabled after reset
// R14 - Bit 6 power-down per pin, default one
// R15 - Three-bit slice level, default 011
// R16 - Host powers up before trusting slice level
// R17 - Synchronise, edge detect, sticky per-pin flag
// R18 - Interrupt held while any flag set
module video_input_select_stb_diag #(
    parameter int input_count = 8
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // Analog routing
    output logic [7:0] analog_input_power_down,
    output logic route_valid,
    output video_input_select_pkg::video_format_t decoder_core_format,
    output logic [2:0] route_first_input,
    output logic [2:0] route_second_input,
    output logic [2:0] route_third_input,
    // Diagnostic comparators
    input wire logic diag_sense_pin_one,
    input wire logic diag_sense_pin_two,
    output logic sense_one_power_down,
    output logic sense_two_power_down,
    output logic [2:0] sense_one_threshold,
    output logic [2:0] sense_two_threshold,
    output logic interrupt_request_pin
);

    // ------------------------------------------------------------
    // Routing decode
    // ------------------------------------------------------------
    // Pair slot k (0..3) to first input index, per variant; 8 flags reserved
    function automatic logic [3:0] pair_base(input logic [1:0] k);
        logic [3:0] base;
        base = 4'h8;
        if (input_count == 8) begin
            base = {1'b0, k, 1'b0};
        end else if (input_count == 6) begin
            case (k)
                2'h0: base = 4'h0;
                2'h1: base = 4'h2;
                2'h3: base = 4'h4;
                default: base = 4'h8;
            endcase
        end else begin
            case (k)
                2'h0: base = 4'h0;
                2'h3: base = 4'h2;
                default: base = 4'h8;
            endcase
        end
        return base;
    endfunction : pair_base

    function automatic video_input_select_pkg::route_t decode_route(input logic [4:0] code);
        video_input_select_pkg::route_t r;
        logic [3:0] base;
        logic [4:0] slot;
        r = '0;
        r.format = video_input_select_pkg::fmt_none;
        base = 4'h8;
        slot = 5'h00;
        if (code <= video_input_select_pkg::code_cvbs_last) begin // [R3]
            if (input_count == 8) begin
                base = {1'b0, code[2:0]};
            end else if (code[2:1] == 2'b11) begin
                base = (input_count == 6) ? {1'b0, 3'(code[2:0] - 3'h2)}
                                          : {1'b0, 3'(code[2:0] - 3'h4)};
            end else if (code[2] == 1'b0 && (input_count == 6 || code[1] == 1'b0)) begin
                base = {1'b0, code[2:0]}; // [R4]
            end
            if (!base[3]) begin
                r.valid = 1'b1;
                r.format = video_input_select_pkg::fmt_cvbs;
                r.first = base[2:0];
                r.used = 8'h01 << base[2:0];
            end
        end else if (code <= video_input_select_pkg::code_yc_last) begin // [R5]
            slot = 5'(code - video_input_select_pkg::code_yc_first);
            base = pair_base(slot[1:0]);
            if (!base[3]) begin
                r.valid = 1'b1;
                r.format = video_input_select_pkg::fmt_luma_chroma;
            end
        end else if (code <= video_input_select_pkg::code_comp_last) begin // [R6]
            slot = 5'(code - video_input_select_pkg::code_comp_first);
            if (input_count == 8 || (input_count == 6 && slot[0] == 1'b0)) begin
                base = slot[0] ? 4'h3 : 4'h0;
                r.valid = 1'b1;
                r.format = video_input_select_pkg::fmt_component;
                r.first = base[2:0];
                r.second = 3'(base[2:0] + 3'h1);
                r.third = 3'(base[2:0] + 3'h2);
                r.used = 8'h07 << base[2:0];
            end
        end else if (code <= video_input_select_pkg::code_diff_last) begin // [R7]
            slot = 5'(code - video_input_select_pkg::code_diff_first);
            base = pair_base(slot[1:0]);
            if (!base[3]) begin
                r.valid = 1'b1;
                r.format = video_input_select_pkg::fmt_diff_cvbs;
            end
        end
        if (r.valid && (r.format == video_input_select_pkg::fmt_luma_chroma ||
                        r.format == video_input_select_pkg::fmt_diff_cvbs)) begin
            r.first = base[2:0];
            r.second = 3'(base[2:0] + 3'h1);
            r.used = 8'h03 << base[2:0];
        end
        return r; // Codes above the differential range stay invalid [R1]
    endfunction : decode_route

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [4:0] input_format_code;
    logic [1:0] event_flag;
    logic [1:0] event_rise;
    logic [1:0] flag_clear;
    video_input_select_pkg::route_t next_route;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            input_format_code <= video_input_select_pkg::format_code_reset;
        end else if (reg_wr && reg_addr == video_input_select_pkg::format_select_offset) begin
            input_format_code <= reg_wdata[4:0]; // [R1]
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            sense_one_power_down <= video_input_select_pkg::power_down_reset; // [R13]
            sense_one_threshold <= video_input_select_pkg::threshold_reset;
        end else if (reg_wr && reg_addr == video_input_select_pkg::sense_one_config_offset) begin
            sense_one_power_down <= reg_wdata[video_input_select_pkg::power_down_bit]; // [R14]
            sense_one_threshold <= reg_wdata[video_input_select_pkg::threshold_lsb +: 3]; // [R15]
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            sense_two_power_down <= video_input_select_pkg::power_down_reset; // [R13]
            sense_two_threshold <= video_input_select_pkg::threshold_reset;
        end else if (reg_wr && reg_addr == video_input_select_pkg::sense_two_config_offset) begin
            sense_two_power_down <= reg_wdata[video_input_select_pkg::power_down_bit]; // [R14]
            sense_two_threshold <= reg_wdata[video_input_select_pkg::threshold_lsb +: 3]; // [R15]
        end
    end

    // Read data registered one cycle after the strobe; unmapped reads give zero
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            case (reg_addr)
                video_input_select_pkg::format_select_offset:
                    reg_rdata <= {3'h0, input_format_code};
                video_input_select_pkg::sense_one_config_offset:
                    reg_rdata <= {1'b0, sense_one_power_down, 1'b0, sense_one_threshold, 2'h0};
                video_input_select_pkg::sense_two_config_offset:
                    reg_rdata <= {1'b0, sense_two_power_down, 1'b0, sense_two_threshold, 2'h0};
                video_input_select_pkg::sense_status_offset:
                    reg_rdata <= {6'h00, event_flag}; // [R12]
                default:
                    reg_rdata <= 8'h00;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Routing outputs
    // ------------------------------------------------------------
    always_comb begin
        next_route = decode_route(input_format_code);
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            route_valid <= 1'b0;
            decoder_core_format <= video_input_select_pkg::fmt_none;
            route_first_input <= 3'h0;
            route_second_input <= 3'h0;
            route_third_input <= 3'h0;
            analog_input_power_down <= 8'hff;
        end else begin
            route_valid <= next_route.valid;
            decoder_core_format <= next_route.format; // [R2]
            route_first_input <= next_route.first;
            route_second_input <= next_route.second;
            route_third_input <= next_route.third;
            // Reserved codes use nothing, so every channel drops [R8]
            analog_input_power_down <= ~next_route.used;
        end
    end

    // ------------------------------------------------------------
    // Short-to-battery diagnostics
    // ------------------------------------------------------------
    // Comparator outputs are asynchronous to this clock [R10]
    sense_event_detect sense_one (
        .clock(clock),
        .rst(rst),
        .compare_async(diag_sense_pin_one),
        .enable(~sense_one_power_down),
        .rise(event_rise[0])
    );

    sense_event_detect sense_two (
        .clock(clock),
        .rst(rst),
        .compare_async(diag_sense_pin_two),
        .enable(~sense_two_power_down),
        .rise(event_rise[1])
    );

    assign flag_clear = (reg_wr && reg_addr == video_input_select_pkg::sense_status_offset)
                        ? reg_wdata[1:0] : 2'b00;

    // Write one to clear; a new edge in the same cycle wins [R17]
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            event_flag <= 2'b00;
        end else begin
            event_flag <= (event_flag & ~flag_clear) | event_rise;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            interrupt_request_pin <= 1'b0;
        end else begin
            interrupt_request_pin <= |event_flag; // [R11] [R18]
        end
    end

endmodule : video_input_select_stb_diag

// ===== hw/video_input_select_pkg.sv
package video_input_select_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [7:0] format_select_offset = 8'h00;
    localparam logic [7:0] sense_one_config_offset = 8'h5d;
    localparam logic [7:0] sense_two_config_offset = 8'h5e;
    localparam logic [7:0] sense_status_offset = 8'h60;

    // ------------------------------------------------------------
    // Field layout
    // ------------------------------------------------------------
    localparam int format_code_lsb = 0;
    localparam int format_code_width = 5;
    localparam int power_down_bit = 6;
    localparam int threshold_lsb = 2;
    localparam int threshold_width = 3;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [4:0] format_code_reset = 5'h00;
    localparam logic power_down_reset = 1'b1;
    localparam logic [2:0] threshold_reset = 3'h3;

    // Slice level: millivolts = base + step * code
    localparam int threshold_base_mv = 75;
    localparam int threshold_step_mv = 150;

    // ------------------------------------------------------------
    // Format codes
    // ------------------------------------------------------------
    localparam logic [4:0] code_cvbs_last = 5'h07;
    localparam logic [4:0] code_yc_first = 5'h08;
    localparam logic [4:0] code_yc_last = 5'h0b;
    localparam logic [4:0] code_comp_first = 5'h0c;
    localparam logic [4:0] code_comp_last = 5'h0d;
    localparam logic [4:0] code_diff_first = 5'h0e;
    localparam logic [4:0] code_diff_last = 5'h11;

    localparam int analog_input_count = 8;
    localparam int sense_pin_count = 2;

    typedef enum logic [2:0] {
        fmt_none = 3'b000,
        fmt_cvbs = 3'b001,
        fmt_diff_cvbs = 3'b010,
        fmt_luma_chroma = 3'b011,
        fmt_component = 3'b100
    } video_format_t;

    typedef struct packed {
        logic valid;
        video_format_t format;
        logic [2:0] first;
        logic [2:0] second;
        logic [2:0] third;
        logic [7:0] used;
    } route_t;

endpackage : video_input_select_pkg

// ===== hw/sense_event_detect.sv
`timescale 1ns/100ps

module sense_event_detect (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Comparator side
    input wire logic compare_async,
    input wire logic enable,
    // Event out
    output logic rise
);

    logic meta;
    logic synced;
    logic prev;
    logic en_meta;
    logic en_synced;

    // Stage one feeds stage two only
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            meta <= 1'b0;
            synced <= 1'b0;
        end else begin
            meta <= compare_async;
            synced <= meta;
        end
    end

    // Enable delayed alongside the data, so samples taken while powered down never count
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            en_meta <= 1'b0;
            en_synced <= 1'b0;
        end else begin
            en_meta <= enable;
            en_synced <= en_meta;
        end
    end

    // Edge held back while powered down, so enabling over a high level still reports it
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            prev <= 1'b0;
            rise <= 1'b0;
        end else begin
            prev <= synced & en_synced;
            rise <= synced & en_synced & ~prev; // [R13]
        end
    end

endmodule : sense_event_detect

// ===== test/diag_connector_model.sv
`timescale 1ns/100ps

module diag_connector_model #(
    parameter int upper_ohms = 3000,
    parameter int lower_ohms = 1000
) (
    // Clock
    input wire logic clock,
    // Device side
    input wire logic power_down,
    input wire logic [2:0] threshold,
    output logic sense,
    // Connector side
    input wire logic [15:0] connector_mv
);
    int pin_mv;
    int slice_mv;
    logic float_level = 1'b0;
    // --------------------------------------------------------
    // Divider and slicer
    // --------------------------------------------------------
    assign pin_mv = int'(connector_mv) * lower_ohms / (upper_ohms + lower_ohms);
    assign slice_mv = video_input_select_pkg::threshold_base_mv
        + video_input_select_pkg::threshold_step_mv * int'(threshold);
    // Unpowered output floats: toggle so a stale level never looks valid
    always @(posedge clock) begin
        float_level <= ~float_level;
    end
    assign sense = power_down ? float_level : (pin_mv > slice_mv);
endmodule : diag_connector_model

// ===== test/video_input_select_stb_diag_checker.sv
`timescale 1ns/100ps

module video_input_select_stb_diag_checker #(
    parameter int input_count = 8
) (
    // Watched ports
    input wire logic clock,
    input wire logic rst,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic [7:0] analog_input_power_down,
    input wire logic route_valid,
    input wire video_input_select_pkg::video_format_t decoder_core_format,
    input wire logic [2:0] route_first_input,
    input wire logic sense_one_power_down,
    input wire logic [2:0] sense_one_threshold,
    input wire logic sense_two_power_down,
    input wire logic interrupt_request_pin
);
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    logic wr_fmt;
    logic clr_wr;
    logic [4:0] c;
    assign wr_fmt = reg_wr && reg_addr == 8'h00 && input_count == 8;
    assign clr_wr = reg_wr && reg_addr == 8'h60 && reg_wdata[1:0] != 2'h0;
    assign c = reg_wdata[4:0];
    // --------------------------------------------------------
    // Routing
    // --------------------------------------------------------
    chk_reserved_no_route:
    assert property (wr_fmt && c >= 5'h12 |-> ##2 !route_valid
        && analog_input_power_down == 8'hff) else $error("reserved code routed");
    chk_cvbs_single_input:
    assert property (wr_fmt && c <= 5'h07 |-> ##2 route_valid && decoder_core_format == 3'h1
        && route_first_input == $past(reg_wdata[2:0], 2)
        && analog_input_power_down == ~(8'h01 << $past(reg_wdata[2:0], 2)))
        else $error("composite routing wrong");
    chk_luma_chroma_pair:
    assert property (wr_fmt && c inside {[5'h08:5'h0b]} |-> ##2 decoder_core_format == 3'h3
        && route_first_input == {$past(reg_wdata[1:0], 2), 1'b0}) else $error("pair wrong");
    chk_component_triple:
    assert property (wr_fmt && c inside {5'h0c, 5'h0d} |-> ##2 decoder_core_format == 3'h4)
        else $error("component wrong");
    chk_diff_pair_mode:
    assert property (wr_fmt && c inside {[5'h0e:5'h11]} |-> ##2 decoder_core_format == 3'h2)
        else $error("differential wrong");
    // --------------------------------------------------------
    // Diagnostics
    // --------------------------------------------------------
    chk_cfg_one_fields:
    assert property (reg_wr && reg_addr == 8'h5d |=> sense_one_power_down == $past(reg_wdata[6])
        && sense_one_threshold == $past(reg_wdata[4:2])) else $error("config not stored");
    chk_irq_holds_flag:
    assert property (interrupt_request_pin && !clr_wr && !$past(clr_wr) |=> interrupt_request_pin)
        else $error("interrupt dropped early");
    chk_irq_needs_power:
    assert property ($rose(interrupt_request_pin) |-> !$past(sense_one_power_down, 5)
        || !$past(sense_two_power_down, 5)) else $error("event while powered down");
    chk_status_read_bits:
    assert property (reg_rd && reg_addr == 8'h60 |=> reg_rdata[7:2] == 6'h00 && (reg_rdata[1:0]
        != 2'h0 || !$past(interrupt_request_pin) || $past(clr_wr, 2))) else $error("bad status");
    cover property ($rose(interrupt_request_pin));
    cover property (wr_fmt && c >= 5'h12);
    cover property (clr_wr ##2 !interrupt_request_pin);
endmodule : video_input_select_stb_diag_checker

// ===== test/video_input_select_stb_diag_tb.sv
`timescale 1ns/100ps

module video_input_select_stb_diag_tb;
    logic clock = 1'b0;
    logic rst;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, analog_input_power_down;
    logic reg_wr, reg_rd, route_valid, interrupt_request_pin;
    video_input_select_pkg::video_format_t decoder_core_format;
    logic [2:0] route_first_input, route_second_input, route_third_input;
    logic diag_sense_pin_one, diag_sense_pin_two;
    logic sense_one_power_down, sense_two_power_down;
    logic [2:0] sense_one_threshold, sense_two_threshold;
    logic [15:0] mv_one, mv_two;
    logic [7:0] four_power_down;
    logic four_valid;
    video_input_select_pkg::video_format_t four_format;
    logic [2:0] four_first, four_second, four_third;
    int checks = 0;
    int fail_count = 0;
    always #2.5 clock = ~clock;
    video_input_select_stb_diag #(.input_count(8)) dut (.clock(clock), .rst(rst),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .analog_input_power_down(analog_input_power_down),
        .route_valid(route_valid), .decoder_core_format(decoder_core_format),
        .route_first_input(route_first_input), .route_second_input(route_second_input),
        .route_third_input(route_third_input), .diag_sense_pin_one(diag_sense_pin_one),
        .diag_sense_pin_two(diag_sense_pin_two), .sense_one_power_down(sense_one_power_down),
        .sense_two_power_down(sense_two_power_down), .sense_one_threshold(sense_one_threshold),
        .sense_two_threshold(sense_two_threshold), .interrupt_request_pin(interrupt_request_pin));
    // Four-input part shares the register port; only its routing is compared
    video_input_select_stb_diag #(.input_count(4)) dut_four (.clock(clock), .rst(rst),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(), .analog_input_power_down(four_power_down), .route_valid(four_valid),
        .decoder_core_format(four_format), .route_first_input(four_first),
        .route_second_input(four_second), .route_third_input(four_third),
        .diag_sense_pin_one(1'b0), .diag_sense_pin_two(1'b0), .sense_one_power_down(),
        .sense_two_power_down(), .sense_one_threshold(), .sense_two_threshold(),
        .interrupt_request_pin());
    diag_connector_model conn_one (.clock(clock), .power_down(sense_one_power_down),
        .threshold(sense_one_threshold), .sense(diag_sense_pin_one), .connector_mv(mv_one));
    diag_connector_model conn_two (.clock(clock), .power_down(sense_two_power_down),
        .threshold(sense_two_threshold), .sense(diag_sense_pin_two), .connector_mv(mv_two));
    // --------------------------------------------------------
    // Tasks
    // --------------------------------------------------------
    task automatic conclude();
        $display("checks %0d fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : conclude
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clock);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clock);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clock);
        reg_rd <= 1'b0;
        #1;
        check({24'h0, reg_rdata}, {24'h0, exp});
    endtask : rd
    task automatic wait_irq(input logic level);
        int n;
        n = 0;
        while (interrupt_request_pin !== level && n < 20) begin
            @(posedge clock);
            #1;
            n++;
        end
        check({31'h0, interrupt_request_pin}, {31'h0, level});
        if (n == 20) conclude();
    endtask : wait_irq
    // Valid, format, first, second, third, power-down for the eight-input part
    function automatic logic [20:0] exp_route(input logic [4:0] c);
        logic [2:0] f;
        f = (c <= 5'h07) ? c[2:0] : (c == 5'h0d) ? 3'h3 : (c == 5'h0c) ? 3'h0
            : (c <= 5'h0b) ? {c[1:0], 1'b0} : {c[1:0] - 2'h2, 1'b0};
        if (c <= 5'h07) return {4'h9, f, 6'h0, ~(8'h01 << f)};
        if (c <= 5'h0b) return {4'hb, f, f + 3'h1, 3'h0, ~(8'h03 << f)};
        if (c <= 5'h0d) return {4'hc, f, f + 3'h1, f + 3'h2, ~(8'h07 << f)};
        if (c <= 5'h11) return {4'ha, f, f + 3'h1, 3'h0, ~(8'h03 << f)};
        return {13'h0, 8'hff};
    endfunction : exp_route
    // Four-input part: component codes route nothing, the host must use manual routing
    function automatic logic [20:0] exp_four(input logic [4:0] c);
        logic [2:0] f;
        f = (c <= 5'h07) ? {1'b0, c[2], c[0]} : (c == 5'h0b || c == 5'h11) ? 3'h2 : 3'h0;
        if (c inside {5'h00, 5'h01, 5'h06, 5'h07}) return {4'h9, f, 6'h0, ~(8'h01 << f)};
        if (c inside {5'h08, 5'h0b}) return {4'hb, f, f + 3'h1, 3'h0, ~(8'h03 << f)};
        if (c inside {5'h0e, 5'h11}) return {4'ha, f, f + 3'h1, 3'h0, ~(8'h03 << f)};
        return {13'h0, 8'hff};
    endfunction : exp_four
    // --------------------------------------------------------
    // Sequence
    // --------------------------------------------------------
    initial begin
        {rst, reg_addr, reg_wdata, reg_wr, reg_rd} = {1'b1, 18'h0};
        {mv_one, mv_two} = 32'h0;
        repeat (2) @(posedge clock);
        rst <= 1'b0;
        for (int c = 0; c < 32; c++) begin
            wr(8'h00, {3'b111, c[4:0]});
            repeat (2) @(posedge clock);
            #1;
            check({11'h0, route_valid, decoder_core_format, route_first_input, route_second_input,
                route_third_input, analog_input_power_down}, {11'h0, exp_route(c[4:0])});
            check({11'h0, four_valid, four_format, four_first, four_second, four_third,
                four_power_down}, {11'h0, exp_four(c[4:0])});
            rd(8'h00, {3'b000, c[4:0]});
        end
        for (int p = 0; p < 2; p++) begin
            rd(8'h5d, 8'h4c);
            rd(8'h5e, 8'h4c);
            rd(8'h33, 8'h00);
            check({24'h0, sense_one_power_down, sense_one_threshold, sense_two_power_down,
                sense_two_threshold}, 32'hbb);
            rd(8'h60, 8'h00);
            if (p == 1) break;
            mv_one <= 16'd4000;
            repeat (12) @(posedge clock);
            rd(8'h60, 8'h00);
            wr(8'h5d, 8'h1c);
            repeat (12) @(posedge clock);
            rd(8'h60, 8'h00);
            mv_one <= 16'd4600;
            wait_irq(1'b1);
            rd(8'h60, 8'h01);
            wr(8'h5e, 8'h00);
            mv_two <= 16'd280;
            repeat (12) @(posedge clock);
            rd(8'h60, 8'h01);
            mv_two <= 16'd320;
            repeat (12) @(posedge clock);
            rd(8'h60, 8'h03);
            wr(8'h60, 8'h01);
            repeat (4) @(posedge clock);
            rd(8'h60, 8'h02);
            wait_irq(1'b1);
            wr(8'h60, 8'h02);
            wait_irq(1'b0);
            wr(8'h5d, 8'h5c);
            repeat (12) @(posedge clock);
            rd(8'h60, 8'h00);
            rst <= 1'b1;
            repeat (2) @(posedge clock);
            rst <= 1'b0;
        end
        conclude();
    end
endmodule : video_input_select_stb_diag_tb

bind video_input_select_stb_diag video_input_select_stb_diag_checker #(
    .input_count(input_count)
) u_checker (.clock(clock), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .analog_input_power_down(analog_input_power_down), .route_valid(route_valid),
    .decoder_core_format(decoder_core_format), .route_first_input(route_first_input),
    .sense_one_power_down(sense_one_power_down), .sense_one_threshold(sense_one_threshold),
    .sense_two_power_down(sense_two_power_down),
    .interrupt_request_pin(interrupt_request_pin));
